// ===== hdl/sdi_ser_defines.vh
// Constants shared by the serializer datapath and its word buffer
`ifndef SDI_SER_DEFINES_VH
`define SDI_SER_DEFINES_VH

// ------------------------------------------------------------
// Word and buffer geometry
// ------------------------------------------------------------
`define WORD_W 10
`define BITS_PER_WORD 4'h9
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define PRIME_WORDS 3'h4

// ------------------------------------------------------------
// Timing reference clipping and decoding
// ------------------------------------------------------------
`define CLIP_LOW_MAX 10'h003
`define CLIP_HIGH_MIN 10'h3FC
`define CLIP_LOW_VAL 10'h000
`define CLIP_HIGH_VAL 10'h3FF
`define TRS_H_BIT 6
`define TRS_V_BIT 7

// ------------------------------------------------------------
// Scrambler taps for x^9 + x^4 + 1
// ------------------------------------------------------------
`define SCR_TAP_A 3
`define SCR_TAP_B 8

// ------------------------------------------------------------
// Clock and lock timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define LOCK_TIME_NS 75000
`define LOCK_CYC (`LOCK_TIME_NS / `CLK_PERIOD_NS)
// Good periods needed before lock: half of LOCK_CYC in words, for margin
`define LOCK_GOOD_WORDS 8'h5D
`define PCLK_PERIOD_LAST 5'h09
`define PCLK_TIMEOUT 5'h14

`endif

// ===== hdl/word_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter W = 11,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [W-1:0] in_data_in,
  input wire in_valid_in,
  output wire in_ready_out,
  output wire [W-1:0] out_data_out,
  output wire out_valid_out,
  input wire out_ready_in
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr_r[AW-1:0]];
  assign do_wr = in_valid_in && !full;
  assign do_rd = out_ready_in && !empty;

  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule

// ===== hdl/sdi_scrambler_serializer.v
// Serial digital video transmit datapath: capture, clip, scramble, NRZI
`timescale 1ns/1ps
`include "sdi_ser_defines.vh"
module sdi_scrambler_serializer (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire pclk_in,
  input wire [9:0] data_in,
  input wire eight_bit_in,
  input wire [1:0] data_type_in,
  input wire sync_det_en_n_in,
  output wire serial_out,
  output wire serial_oe_n_out,
  output wire lock_out,
  output wire video_valid_out,
  output wire overrun_out
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function is_ones;
    input [9:0] w;
    begin
      is_ones = (w >= `CLIP_HIGH_MIN);
    end
  endfunction

  function is_zeros;
    input [9:0] w;
    begin
      is_zeros = (w <= `CLIP_LOW_MAX);
    end
  endfunction

  function [9:0] clip;
    input [9:0] w;
    begin
      if (is_ones(w)) begin
        clip = `CLIP_HIGH_VAL;
      end else if (is_zeros(w)) begin
        clip = `CLIP_LOW_VAL;
      end else begin
        clip = w;
      end
    end
  endfunction

  // Every video type widens the same way: the low bits are fractional
  function [9:0] widen;
    input [9:0] d;
    input eight;
    input [1:0] kind;
    begin
      if (eight) begin
        case (kind)
          2'h0: widen = {d[7:0], 2'h0};
          2'h1: widen = {d[7:0], 2'h0};
          default: widen = {d[7:0], 2'h0};
        endcase
      end else begin
        widen = d;
      end
    end
  endfunction

  function last_bit;
    input [3:0] cnt;
    begin
      last_bit = (cnt == `BITS_PER_WORD);
    end
  endfunction

  // ------------------------------------------------------------
  // Word clock edge and run control
  // ------------------------------------------------------------
  reg pclk_d_r;
  reg run_r;
  wire pe;

  // Undriven pins are resolved low by the pad; here a low pclk never edges
  assign pe = pclk_in && !pclk_d_r;

  // Everything downstream stays in reset until the first word clock edge
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pclk_d_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      pclk_d_r <= pclk_in;
      if (pe) begin
        run_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Lock detection: word clock period must be ten bit times
  // ------------------------------------------------------------
  reg [4:0] per_cnt_r;
  reg [7:0] good_cnt_r;
  reg lock_r;

  // Many good periods are needed so that a short burst cannot raise lock
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !run_r) begin
      per_cnt_r <= 5'h00;
      good_cnt_r <= 8'h00;
      lock_r <= 1'b0;
    end else if (pe) begin
      per_cnt_r <= 5'h00;
      if (per_cnt_r == `PCLK_PERIOD_LAST) begin
        if (good_cnt_r == `LOCK_GOOD_WORDS) begin
          lock_r <= 1'b1;
        end else begin
          good_cnt_r <= good_cnt_r + 8'h01;
        end
      end else begin
        good_cnt_r <= 8'h00;
        lock_r <= 1'b0;
      end
    end else if (per_cnt_r == `PCLK_TIMEOUT) begin
      // Word clock stopped: the reference is gone
      good_cnt_r <= 8'h00;
      lock_r <= 1'b0;
    end else begin
      per_cnt_r <= per_cnt_r + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // Input register and timing reference pipeline
  // ------------------------------------------------------------
  reg [9:0] cap_r;
  reg [9:0] w0_r;
  reg [9:0] w1_r;
  reg [9:0] w2_r;
  reg c1_r;
  reg c2_r;
  reg x0_r;
  reg x1_r;
  reg x2_r;
  reg [2:0] prime_r;
  reg vid_r;
  reg overrun_r;
  wire match;
  wire primed;
  wire [9:0] emit_word;
  wire fifo_in_ready;
  wire fifo_push;

  // Three words are held back so a whole preamble is seen before clipping
  assign match = !sync_det_en_n_in && is_ones(w2_r) && is_zeros(w1_r)
                 && is_zeros(w0_r);
  assign primed = (prime_r == `PRIME_WORDS);
  assign emit_word = (c2_r || match) ? clip(w2_r) : w2_r;
  assign fifo_push = pe && primed;

  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !run_r) begin
      cap_r <= 10'h000;
      w0_r <= 10'h000;
      w1_r <= 10'h000;
      w2_r <= 10'h000;
      c1_r <= 1'b0;
      c2_r <= 1'b0;
      x0_r <= 1'b0;
      x1_r <= 1'b0;
      x2_r <= 1'b0;
      prime_r <= 3'h0;
      vid_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      // One pulse for each word dropped at a full buffer
      overrun_r <= fifo_push && !fifo_in_ready;
      if (pe) begin
        cap_r <= widen(data_in, eight_bit_in, data_type_in);
        w0_r <= cap_r;
        w1_r <= w0_r;
        w2_r <= w1_r;
        // The head word clips on the match, its two low words after it
        c1_r <= match;
        c2_r <= c1_r || match;
        x0_r <= match;
        x1_r <= x0_r;
        x2_r <= x1_r;
        if (!primed) begin
          prime_r <= prime_r + 3'h1;
        end
        if (x2_r && !sync_det_en_n_in) begin
          // Start of active video with field blanking clear opens video
          vid_r <= !w2_r[`TRS_H_BIT] && !w2_r[`TRS_V_BIT];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Word buffer between word clock and serial timing
  // ------------------------------------------------------------
  wire [10:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_pop;
  reg [3:0] bit_cnt_r;

  // A push that meets a full buffer is dropped even if a pop lands in the
  // same cycle; the buffer then settles one word below full and the pushed word is lost
  assign fifo_pop = lock_r && last_bit(bit_cnt_r);

  word_fifo #(
    .W(11),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_in && run_r),
    .in_data_in({vid_r, emit_word}),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .out_data_out(fifo_out_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop)
  );

  // ------------------------------------------------------------
  // Serializer, scrambler and NRZI encoder
  // ------------------------------------------------------------
  reg [9:0] sh_r;
  reg [8:0] scr_r;
  reg nrzi_r;
  reg oe_n_r;
  reg vid_out_r;
  reg [9:0] sh_nxt;
  reg [8:0] scr_nxt;
  reg nrzi_nxt;
  reg scr_bit;

  // The shifter starts empty, so the first ten bits after lock are zeros
  always @* begin
    scr_bit = sh_r[0] ^ scr_r[`SCR_TAP_A] ^ scr_r[`SCR_TAP_B];
    scr_nxt = {scr_r[7:0], scr_bit};
    nrzi_nxt = nrzi_r ^ scr_bit;
    if (last_bit(bit_cnt_r)) begin
      // An empty buffer sends zero words rather than pausing the line
      sh_nxt = fifo_out_valid ? fifo_out_data[9:0] : 10'h000;
    end else begin
      sh_nxt = {1'b0, sh_r[9:1]};
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !run_r) begin
      sh_r <= 10'h000;
      scr_r <= 9'h000;
      nrzi_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      oe_n_r <= 1'b1;
      vid_out_r <= 1'b0;
    end else begin
      oe_n_r <= 1'b0;
      if (lock_r) begin
        sh_r <= sh_nxt;
        scr_r <= scr_nxt;
        nrzi_r <= nrzi_nxt;
        if (last_bit(bit_cnt_r)) begin
          bit_cnt_r <= 4'h0;
          vid_out_r <= fifo_out_valid && fifo_out_data[10];
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end else begin
        // Out of lock the line level freezes
        bit_cnt_r <= 4'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign serial_out = nrzi_r;
  assign serial_oe_n_out = oe_n_r;
  assign lock_out = lock_r;
  assign video_valid_out = vid_out_r;
  assign overrun_out = overrun_r;

endmodule

// ===== dv/sdi_ser_props_properties.sv
// Port checker for the serializer datapath
`timescale 1ns/1ps
module sdi_ser_checker (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire pclk_in,
  input wire serial_out,
  input wire serial_oe_n_out,
  input wire lock_out,
  input wire video_valid_out,
  input wire overrun_out
);
  reg pq_r;
  reg [5:0] gap_r;
  reg [11:0] up_r;
  always @(posedge ref_clk_in) begin
    pq_r <= pclk_in;
    gap_r <= (pclk_in && !pq_r) ? 6'h00 : gap_r + {5'h00, gap_r != 6'h3F};
    up_r <= rst_n_in ? up_r + {11'h000, up_r != 12'hFFF} : 12'h000;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_quiet:
  assert property (disable iff (1'b0) !rst_n_in |=> serial_oe_n_out && !lock_out
    && !serial_out && !video_valid_out) else $error("reset state wrong");
  a_oe_held:
  assert property (!serial_oe_n_out |=> !serial_oe_n_out) else $error("driver dropped");
  a_oe_on_edge:
  assert property ($fell(serial_oe_n_out) |-> $past(pclk_in)) else $error("early enable");
  a_lock_drives:
  assert property (lock_out |-> !serial_oe_n_out) else $error("locked, driver off");
  a_static_unlocked:
  assert property (!lock_out |=> $stable(serial_out)) else $error("serial moved");
  a_lock_time:
  assert property ($rose(lock_out) |-> up_r >= 12'h384 && up_r <= 12'h753) else $error("lock time");
  a_lock_timeout:
  assert property (lock_out |-> gap_r <= 6'h17) else $error("lock without clock");
  a_overrun_pulse:
  assert property (overrun_out |-> $past(pclk_in) ##1 !overrun_out) else $error("overrun");
endmodule

bind sdi_scrambler_serializer sdi_ser_checker u_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .pclk_in(pclk_in),
  .serial_out(serial_out), .serial_oe_n_out(serial_oe_n_out), .lock_out(lock_out),
  .video_valid_out(video_valid_out), .overrun_out(overrun_out)
);

// ===== dv/video_partner.sv
// Word clock source and serial receiver model
`timescale 1ns/1ps
module video_partner (
  input wire ref_clk_in,
  input wire run_in,
  input wire serial_in,
  output reg pclk_out,
  output reg [9:0] win_out
);
  reg [3:0] cnt_r = 4'h0;
  reg last_r = 1'b0;
  reg [8:0] hist_r = 9'h000;
  wire d;
  assign d = serial_in ^ last_r;
  initial pclk_out = 1'b0;
  initial win_out = 10'h000;
  // Descrambler is self-synchronising, so no reset is needed here
  always @(posedge ref_clk_in) begin
    cnt_r <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
    pclk_out <= #1 run_in && cnt_r < 4'h5;
    last_r <= serial_in;
    hist_r <= {hist_r[7:0], d};
    win_out <= {d ^ hist_r[3] ^ hist_r[8], win_out[9:1]};
  end
endmodule

// ===== dv/sdi_scrambler_serializer_tb_top.sv
// Self-checking bench for the serializer datapath
`timescale 1ns/1ps
module sdi_scrambler_serializer_tb_top;
  reg ref_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg run = 1'b0;
  reg [9:0] data_in = 10'h000;
  reg eight_bit_in = 1'b0;
  reg [1:0] data_type_in = 2'h0;
  reg sync_det_en_n_in = 1'b1;
  wire pclk_in, serial_out, serial_oe_n_out, lock_out, video_valid_out, overrun_out;
  wire [9:0] win;
  integer n_fail = 0;
  integer samples_checked = 0;
  integer nsent = 0, npop = 0, ph = 0, i;
  integer n_ovr = 0, ovr_mark = 0;
  reg [22:0] it;
  reg [22:0] txq[$];
  reg [9:0] expq[$];
  always #20 ref_clk_in = ~ref_clk_in;
  sdi_scrambler_serializer DUT (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .pclk_in(pclk_in), .data_in(data_in),
    .eight_bit_in(eight_bit_in), .data_type_in(data_type_in),
    .sync_det_en_n_in(sync_det_en_n_in), .serial_out(serial_out),
    .serial_oe_n_out(serial_oe_n_out), .lock_out(lock_out),
    .video_valid_out(video_valid_out), .overrun_out(overrun_out)
  );
  video_partner src (.ref_clk_in(ref_clk_in), .run_in(run), .serial_in(serial_out),
    .pclk_out(pclk_in), .win_out(win));
  task check(input [9:0] s, input [9:0] w);
    begin
      samples_checked = samples_checked + 1;
      if (s !== w) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED t=%0t seen=%h want=%h", $time, s, w);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task put(input [12:0] c, input [9:0] e);
    txq.push_back({c, e});
  endtask
  task drain;
    integer k;
    integer tgt;
    begin
      for (k = 0; txq.size() > 0 && k < 99; k = k + 1) @(posedge ref_clk_in);
      tgt = nsent;
      for (k = 0; npop < tgt && k < 500; k = k + 1) @(posedge ref_clk_in);
      #1;
      if (npop < tgt || txq.size() > 0) begin
        n_fail = n_fail + 1;
        report_and_stop;
      end
    end
  endtask
  task wait_lock(input v, input integer lim);
    integer k;
    begin
      for (k = 0; lock_out !== v && k < lim; k = k + 1) begin
        @(posedge ref_clk_in);
        #1;
      end
      check({9'h000, lock_out}, {9'h000, v});
    end
  endtask
  // Dropped words are counted mid-cycle, where the pulse has settled
  always @(negedge ref_clk_in) begin
    if (overrun_out === 1'b1)
      n_ovr <= n_ovr + 1;
  end
  // Every word clock carries a word; idle slots send zero so the stream stays in step
  always @(posedge pclk_in) begin
    it = (txq.size() > 0) ? txq.pop_front() : 23'h000000;
    {eight_bit_in, data_type_in, data_in} <= it[22:10];
    expq.push_back(it[9:0]);
    nsent = nsent + 1;
  end
  always @(posedge ref_clk_in) begin
    #1;
    if (ph == 0 && win === 10'h3FF) begin
      while (expq.size() > 0 && expq[0] !== 10'h3FF) begin
        void'(expq.pop_front());
        npop = npop + 1;
      end
      ph = 10;
    end
    if (ph > 0)
      ph = ph + 1;
    if (ph == 11) begin
      ph = 1;
      npop = npop + 1;
      check(win, expq.pop_front());
    end
  end
  task t_reset;
    begin
      check({6'h00, serial_out, serial_oe_n_out, lock_out, video_valid_out}, 10'h004);
      run = 1'b1;
      wait_lock(1'b1, 1875);
      check({9'h000, serial_oe_n_out}, 10'h000);
      check({9'h000, n_ovr != 0}, 10'h001);
    end
  endtask
  task t_stream;
    begin
      sync_det_en_n_in = 1'b1;
      put(13'h03FF, 10'h3FF);
      put(13'h0155, 10'h155);
      put(13'h02AA, 10'h2AA);
      put(13'h03FD, 10'h3FD);
      put(13'h0002, 10'h002);
      put(13'h0001, 10'h001);
      put(13'h0200, 10'h200);
      drain;
      check({9'h000, video_valid_out}, 10'h000);
    end
  endtask
  task t_eight;
    begin
      ovr_mark = n_ovr;
      for (i = 0; i < 4; i = i + 1)
        put({1'b1, i[1:0], 10'h3A5}, 10'h294);
      drain;
    end
  endtask
  task t_clip;
    begin
      sync_det_en_n_in = 1'b0;
      put(13'h03FD, 10'h3FF);
      put(13'h0002, 10'h000);
      put(13'h0001, 10'h000);
      put(13'h0200, 10'h200);
      drain;
      check({9'h000, video_valid_out}, 10'h001);
      check({9'h000, n_ovr != ovr_mark}, 10'h000);
    end
  endtask
  task t_stop;
    begin
      ph = -1;
      run = 1'b0;
      wait_lock(1'b0, 30);
      check({9'h000, serial_oe_n_out}, 10'h000);
      rst_n_in = 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
      check({6'h00, serial_out, serial_oe_n_out, lock_out, video_valid_out}, 10'h004);
      rst_n_in = 1'b1;
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    t_reset;
    t_stream;
    t_eight;
    t_clip;
    t_stop;
    report_and_stop;
  end
endmodule
